// [design/uart_sb_pkg.sv]
/*
  Shared constants and types for the serial channel status and buffer block:
  register offsets, field positions, reset values, parity modes and states.
  Assumes a 20 MHz system clock and a byte-wide register port.
*/
package uart_sb_pkg;

  // System clock and default line rate
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned BAUD_DEFAULT = 9600;
  localparam int unsigned BIT_CYCLES_DEFAULT = CLK_HZ / BAUD_DEFAULT;
  localparam int unsigned CNT_W = 16;

  // Register offsets on the byte port
  localparam logic [2:0] OFS_MODE = 3'h0;
  localparam logic [2:0] OFS_ERR = 3'h1;
  localparam logic [2:0] OFS_TXP = 3'h2;
  localparam logic [2:0] OFS_RXB = 3'h3;
  localparam logic [2:0] OFS_TXB = 3'h4;

  // Values after reset
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [2:0] ERR_RESET = 3'h0;
  localparam logic [7:0] RXB_RESET = 8'hFF;
  localparam logic [7:0] TXB_RESET = 8'hFF;

  // Channel mode register fields
  localparam int unsigned MODE_CH_EN = 7;
  localparam int unsigned MODE_TX_EN = 6;
  localparam int unsigned MODE_RX_EN = 5;
  localparam int unsigned MODE_PS_HI = 4;
  localparam int unsigned MODE_PS_LO = 3;
  localparam int unsigned MODE_CL = 2;
  localparam int unsigned MODE_SL = 1;
  localparam int unsigned MODE_ISRM = 0;

  // Receive error status fields
  localparam int unsigned ERR_PE = 2;
  localparam int unsigned ERR_FE = 1;
  localparam int unsigned ERR_OVE = 0;

  // Transmit progress status fields
  localparam int unsigned TXP_TXBF = 1;
  localparam int unsigned TXP_TXSF = 0;

  // Parity selection, in field order
  typedef enum logic [1:0] {PAR_NONE, PAR_ZERO, PAR_ODD, PAR_EVEN} parity_t;

  // Transmit and receive sequencer states
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

endpackage : uart_sb_pkg

// [design/uart_frame_rx.sv]
/*
  Receive frame sequencer: finds a start bit, samples data, parity and the
  first stop bit at mid-bit, then pulses done with the captured fields.
  Assumes rxd_i is already synchronised to clk_i.
*/
`timescale 1ns/1ps
module uart_frame_rx
  import uart_sb_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEFAULT
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic rxd_i,
  input wire logic char8_i,
  input wire logic par_en_i,
  output logic done_o,
  output logic [7:0] data_o,
  output logic par_o,
  output logic stop_ok_o
);

  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(BIT_CYCLES / 2 - 1);

  typedef struct packed {
    rx_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [2:0] idx;
    logic [7:0] data;
    logic par;
    logic stop_ok;
    logic done;
  } frx_t;

  frx_t s;
  frx_t n;

  // Sequencer; one stop bit only, whatever the transmit stop length
  always_comb
  begin
    n = s;
    n.done = 1'b0;
    if (s.cnt != '0)
      n.cnt = s.cnt - CNT_W'(1);
    case (s.st)
      RX_IDLE:
      begin
        if (!rxd_i)
        begin
          n.st = RX_START;
          n.cnt = HALF_LAST;
        end
      end
      RX_START:
      begin
        if (s.cnt == '0)
        begin
          // A high level at mid start bit is a glitch
          n.st = rxd_i ? RX_IDLE : RX_DATA;
          n.cnt = BIT_LAST;
          n.idx = 3'h0;
          n.data = 8'h00; // Bit 7 stays zero for 7-bit characters
        end
      end
      RX_DATA:
      begin
        if (s.cnt == '0)
        begin
          n.data[s.idx] = rxd_i;
          n.cnt = BIT_LAST;
          n.idx = 3'(s.idx + 3'h1);
          if (s.idx == (char8_i ? 3'h7 : 3'h6))
            n.st = par_en_i ? RX_PAR : RX_STOP;
        end
      end
      RX_PAR:
      begin
        if (s.cnt == '0)
        begin
          n.par = rxd_i;
          n.cnt = BIT_LAST;
          n.st = RX_STOP;
        end
      end
      RX_STOP:
      begin
        if (s.cnt == '0)
        begin
          n.stop_ok = rxd_i;
          n.done = 1'b1;
          n.st = RX_IDLE;
        end
      end
      default:
        n.st = RX_IDLE;
    endcase
    if (!enable_i)
    begin
      n.st = RX_IDLE;
      n.done = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '{st: RX_IDLE, cnt: '0, idx: 3'h0, data: 8'h00, par: 1'b0,
             stop_ok: 1'b1, done: 1'b0};
    else
      s <= n;
  end

  assign done_o = s.done;
  assign data_o = s.data;
  assign par_o = s.par;
  assign stop_ok_o = s.stop_ok;

endmodule : uart_frame_rx

// [design/uart_status_buffers.sv]
/*
  Status and buffer logic of one asynchronous serial channel: mode, receive
  error status, transmit progress, receive and transmit byte holding, with
  the transmit sequencer and the completion pulses.
  Assumes a byte register port with read data one cycle after the strobe,
  and a line input from another domain.
*/
// The register addresses and the address-and-strobe port were decided locally.
// Overview of operation
// - Reading error status clears all its bits
// - Channel or receive disable clears error flags
// - Parity mismatch at frame end sets parity error
// - Parity checking follows two-bit parity selection
// - Stop bit sampled low sets framing error
// - Frame completing over unread byte sets overrun
// - On overrun, new byte discarded, buffer kept
// - Writing transmit buffer sets buffer-full flag
// - Buffer-full clears on load or disable
// - Loading shift register sets shift-busy flag
// - Shift-busy clears at idle frame end, disable
// - Frame end copies to receive buffer, interrupts
// - Receive enable off, channel on: buffer kept, no interrupt
// - Seven-bit characters read with bit 7 zero
// - Receive buffer all ones at reset, channel off
// - Transmit buffer write starts transmission when enabled
// - Transmit buffer writes ignored while transmit disabled
// - Transmit completion pulse at each frame end
// - Transmit buffer all ones at system reset
// - Receiver always checks a single stop bit
// - Zero-parity mode never flags parity errors
`timescale 1ns/1ps
module uart_status_buffers
  import uart_sb_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEFAULT
)(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic RXD_I,
  output logic TXD_O,
  output logic RX_DONE_O,
  output logic RX_ERR_O,
  output logic TX_DONE_O
);

  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);

  typedef struct packed {
    logic rxd_meta;
    logic rxd_sync;
    logic [7:0] mode;
    logic [2:0] err;
    logic [7:0] rx_hold;
    logic rx_unread;
    logic [7:0] tx_hold;
    logic txbf;
    logic txsf;
    tx_state_t tx_st;
    logic [CNT_W-1:0] tx_cnt;
    logic [2:0] tx_idx;
    logic [7:0] tx_shift;
    logic tx_stop2;
    logic txd;
    logic [7:0] rdata;
    logic rx_done;
    logic rx_err;
    logic tx_done;
  } state_t;

  localparam state_t ST_RESET = '{
    rxd_meta: 1'b1, rxd_sync: 1'b1, mode: MODE_RESET, err: ERR_RESET,
    rx_hold: RXB_RESET, rx_unread: 1'b0, tx_hold: TXB_RESET, txbf: 1'b0,
    txsf: 1'b0, tx_st: TX_IDLE, tx_cnt: '0, tx_idx: 3'h0, tx_shift: 8'h00,
    tx_stop2: 1'b0, txd: 1'b1, rdata: 8'h00, rx_done: 1'b0, rx_err: 1'b0,
    tx_done: 1'b0};

  state_t s;
  state_t n;

  // Decoded mode
  logic ch_en;
  logic rx_on;
  logic tx_on;
  logic char8;
  parity_t psel;
  logic [2:0] last_idx;
  assign ch_en = s.mode[MODE_CH_EN];
  assign rx_on = ch_en && s.mode[MODE_RX_EN];
  assign tx_on = ch_en && s.mode[MODE_TX_EN];
  assign char8 = s.mode[MODE_CL];
  assign psel = parity_t'({s.mode[MODE_PS_HI], s.mode[MODE_PS_LO]});
  assign last_idx = char8 ? 3'h7 : 3'h6;

  // Receive frame sequencer
  logic fr_done;
  logic [7:0] fr_data;
  logic fr_par;
  logic fr_stop_ok;

  uart_frame_rx #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_frame_rx (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .enable_i(rx_on),
    .rxd_i(s.rxd_sync),
    .char8_i(char8),
    .par_en_i(psel != PAR_NONE),
    .done_o(fr_done),
    .data_o(fr_data),
    .par_o(fr_par),
    .stop_ok_o(fr_stop_ok)
  );

  // Frame-end error detection
  logic frame_end;
  logic par_calc;
  logic pe_new;
  logic fe_new;
  logic ove_new;
  logic [2:0] err_new;
  assign frame_end = fr_done && rx_on;
  assign par_calc = ^fr_data;
  // Odd and even modes judge; none and zero modes never flag
  assign pe_new = frame_end && ((psel == PAR_ODD && fr_par == par_calc) ||
                                (psel == PAR_EVEN && fr_par != par_calc));
  assign fe_new = frame_end && !fr_stop_ok;
  assign ove_new = frame_end && s.rx_unread;
  always_comb
  begin
    err_new = 3'h0;
    err_new[ERR_PE] = pe_new;
    err_new[ERR_FE] = fe_new;
    err_new[ERR_OVE] = ove_new;
  end

  // Register strobes
  logic rd_err;
  logic rd_rxb;
  logic wr_txb;
  assign rd_err = RD_I && ADDR_I == OFS_ERR;
  assign rd_rxb = RD_I && ADDR_I == OFS_RXB;
  assign wr_txb = WR_I && ADDR_I == OFS_TXB;

  // Next state of the whole channel
  always_comb
  begin
    logic do_load;
    do_load = 1'b0;
    n = s;
    n.rx_done = 1'b0;
    n.rx_err = 1'b0;
    n.tx_done = 1'b0;
    n.rdata = 8'h00;
    // Line input synchroniser
    n.rxd_meta = RXD_I;
    n.rxd_sync = s.rxd_meta;

    // Mode register write
    if (WR_I && ADDR_I == OFS_MODE)
      n.mode = WDATA_I;

    // Read data, answered one cycle later; unmapped reads give zero
    if (RD_I)
    begin
      case (ADDR_I)
        OFS_MODE: n.rdata = s.mode;
        OFS_ERR: n.rdata = {5'h00, s.err};
        OFS_TXP: n.rdata = {6'h00, s.txbf, s.txsf};
        OFS_RXB: n.rdata = s.rx_hold;
        OFS_TXB: n.rdata = s.tx_hold;
        default: n.rdata = 8'h00;
      endcase
    end

    // Status read clears; a new error in that cycle still lands
    n.err = (rd_err ? 3'h0 : s.err) | err_new;
    if (!rx_on)
      n.err = 3'h0;

    // Receive buffer read frees it; a transfer the same cycle wins
    if (rd_rxb)
      n.rx_unread = 1'b0;
    if (frame_end)
    begin
      if (!s.rx_unread)
      begin
        n.rx_hold = fr_data;
        n.rx_unread = 1'b1;
      end
      // Errors go to the error pulse unless routed to completion
      if (err_new != 3'h0 && !s.mode[MODE_ISRM])
        n.rx_err = 1'b1;
      else
        n.rx_done = 1'b1;
    end
    // Overrun keeps the older byte: the branch above is skipped
    if (!ch_en)
    begin
      n.rx_hold = RXB_RESET;
      n.rx_unread = 1'b0;
    end

    // Transmit sequencer, one bit period per state step
    if (s.tx_cnt != '0)
      n.tx_cnt = s.tx_cnt - CNT_W'(1);
    case (s.tx_st)
      TX_IDLE:
      begin
        n.txd = 1'b1;
        do_load = s.txbf;
      end
      TX_START:
      begin
        if (s.tx_cnt == '0)
        begin
          n.tx_st = TX_DATA;
          n.tx_idx = 3'h0;
          n.txd = s.tx_shift[0];
          n.tx_cnt = BIT_LAST;
        end
      end
      TX_DATA:
      begin
        if (s.tx_cnt == '0)
        begin
          n.tx_cnt = BIT_LAST;
          if (s.tx_idx == last_idx)
          begin
            if (psel == PAR_NONE)
            begin
              n.tx_st = TX_STOP;
              n.txd = 1'b1;
              n.tx_stop2 = s.mode[MODE_SL];
            end
            else
            begin
              n.tx_st = TX_PAR;
              // Zero mode sends 0; odd inverts the data parity
              n.txd = (psel == PAR_ZERO) ? 1'b0 :
                      (psel == PAR_ODD) ? ~(^s.tx_shift) : ^s.tx_shift;
            end
          end
          else
          begin
            n.tx_idx = 3'(s.tx_idx + 3'h1);
            n.txd = s.tx_shift[3'(s.tx_idx + 3'h1)];
          end
        end
      end
      TX_PAR:
      begin
        if (s.tx_cnt == '0)
        begin
          n.tx_st = TX_STOP;
          n.txd = 1'b1;
          n.tx_stop2 = s.mode[MODE_SL];
          n.tx_cnt = BIT_LAST;
        end
      end
      TX_STOP:
      begin
        if (s.tx_cnt == '0)
        begin
          if (s.tx_stop2)
          begin
            n.tx_stop2 = 1'b0;
            n.tx_cnt = BIT_LAST;
          end
          else
          begin
            n.tx_done = 1'b1;
            // Back-to-back frames when a byte is already waiting
            do_load = s.txbf;
            if (!s.txbf)
            begin
              n.tx_st = TX_IDLE;
              n.txsf = 1'b0;
            end
          end
        end
      end
      default:
        n.tx_st = TX_IDLE;
    endcase

    // Move the waiting byte into the shift register
    if (do_load)
    begin
      n.tx_shift = char8 ? s.tx_hold : {1'b0, s.tx_hold[6:0]};
      n.txbf = 1'b0;
      n.txsf = 1'b1;
      n.tx_st = TX_START;
      n.tx_cnt = BIT_LAST;
      n.txd = 1'b0;
    end

    // Buffer write; writing while full is the software's fault
    if (wr_txb && tx_on)
    begin
      n.tx_hold = WDATA_I;
      n.txbf = 1'b1;
    end

    // Disabled transmitter idles high and drops both flags
    if (!tx_on)
    begin
      n.tx_st = TX_IDLE;
      n.txbf = 1'b0;
      n.txsf = 1'b0;
      n.txd = 1'b1;
      n.tx_done = 1'b0;
    end
  end

  // State register; system reset restores buffers to all ones
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      s <= ST_RESET;
    else
      s <= n;
  end

  assign RDATA_O = s.rdata;
  assign TXD_O = s.txd;
  assign RX_DONE_O = s.rx_done;
  assign RX_ERR_O = s.rx_err;
  assign TX_DONE_O = s.tx_done;

  // Checks next to the logic they guard
  status_read_clear_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    rd_err && rx_on |=> s.err == $past(err_new))
    else $error("status read did not clear to new errors");

  disable_clears_err_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !rx_on |=> s.err == 3'h0)
    else $error("error flags kept while reception off");

  zero_parity_quiet_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    frame_end && psel == PAR_ZERO && !s.err[ERR_PE] |=> !s.err[ERR_PE])
    else $error("parity error flagged in zero parity mode");

  overrun_keeps_hold_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    frame_end && s.rx_unread && ch_en |=> s.err[ERR_OVE] && $stable(s.rx_hold))
    else $error("overrun byte overwrote receive buffer");

  txbf_on_write_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    wr_txb && tx_on |=> s.txbf && s.tx_hold == $past(WDATA_I))
    else $error("buffer write did not set full flag");

  tx_write_ignored_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    wr_txb && !tx_on |=> !s.txbf && $stable(s.tx_hold))
    else $error("write taken while transmit disabled");

  load_sets_busy_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    s.tx_st == TX_IDLE && s.txbf && tx_on |=> !s.txbf && s.txsf ##1 !TXD_O)
    else $error("load did not move flags or start bit");

  rx_off_kept_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    ch_en && !s.mode[MODE_RX_EN] |=> $stable(s.rx_hold) && !RX_DONE_O)
    else $error("receive buffer changed while reception off");

  rx_hold_ones_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !ch_en |=> s.rx_hold == RXB_RESET)
    else $error("receive buffer not all ones with channel off");

endmodule : uart_status_buffers

// [test/uart_sb_station.sv]
/*
  Remote serial station: sends a prepared frame on the line into the block
  and decodes 8-bit, no-parity frames that the block transmits.
  Assumes the bench holds frame and length steady from go until busy falls.
*/
`timescale 1ns/1ps
module uart_sb_station #(
  parameter int unsigned BIT_CYCLES = 8
)(
  input wire logic clk_i,
  input wire logic [11:0] frame_i,
  input wire logic [3:0] len_i,
  input wire logic go_i,
  output logic rxd_o,
  output logic busy_o,
  input wire logic txd_i,
  output logic got_o,
  output logic [7:0] got_byte_o
);
  int k;
  int j;
  logic [7:0] shift;

  // Idle line is high, as a pulled-up line would be
  initial
  begin
    rxd_o = 1'b1;
    busy_o = 1'b0;
    got_o = 1'b0;
    got_byte_o = 8'h00;
  end

  // Sender: LSB first, one bit every BIT_CYCLES
  always
  begin
    @(posedge clk_i);
    if (go_i === 1'b1)
    begin
      busy_o <= 1'b1;
      for (k = 0; k < int'(len_i); k++)
      begin
        rxd_o <= frame_i[k];
        repeat (BIT_CYCLES) @(posedge clk_i);
      end
      rxd_o <= 1'b1;
      busy_o <= 1'b0;
    end
  end

  // Receiver: mid-bit sampling, stop bit not judged
  always
  begin
    @(negedge txd_i);
    repeat (BIT_CYCLES / 2) @(posedge clk_i);
    for (j = 0; j < 8; j++)
    begin
      repeat (BIT_CYCLES) @(posedge clk_i);
      shift[j] = txd_i;
    end
    repeat (BIT_CYCLES) @(posedge clk_i);
    got_byte_o <= shift;
    got_o <= 1'b1;
    @(posedge clk_i);
    got_o <= 1'b0;
  end
endmodule : uart_sb_station

// [test/test_uart_status_buffers.sv]
/*
  Self-checking bench for the serial channel status and buffer block.
  Assumes the remote station model and a short bit period of 8 cycles.
*/
`timescale 1ns/1ps
module test_uart_status_buffers;
  import uart_sb_pkg::*;
  localparam int unsigned BC = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [11:0] frame = 12'hFFF;
  logic [3:0] len = 4'h1;
  logic [7:0] rdata, got_byte, v, a, b;
  logic rxd, txd, rx_done, rx_err, tx_done, busy, got;
  logic [7:0] rxq[$];
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_rxd = 0;
  int n_rxe = 0;
  int n_txd = 0;
  int base, ps, flip, c8, i;

  // Clock, 50 ns period
  always #25 clk = ~clk;

  uart_status_buffers #(.BIT_CYCLES(BC)) uart_status_buffers_inst (.CLK_I(clk), .RST_I(rst),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RXD_I(rxd),
    .TXD_O(txd), .RX_DONE_O(rx_done), .RX_ERR_O(rx_err), .TX_DONE_O(tx_done));

  uart_sb_station #(.BIT_CYCLES(BC)) uart_sb_station_inst (.clk_i(clk), .frame_i(frame),
    .len_i(len), .go_i(go), .rxd_o(rxd), .busy_o(busy), .txd_i(txd), .got_o(got),
    .got_byte_o(got_byte));

  // Pulse counters, line capture and hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (rx_done === 1'b1) n_rxd++;
    if (rx_err === 1'b1) n_rxe++;
    if (tx_done === 1'b1) n_txd++;
    if (got === 1'b1) rxq.push_back(got_byte);
    if (cycles == 30000)
    begin
      n_errors++;
      test_done();
    end
  end

  task test_done;
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task chk(input logic [7:0] got_v, input logic [7:0] exp_v);
    samples_checked++;
    if (got_v !== exp_v)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got_v, exp_v);
    end
  endtask : chk

  task reg_wr(input logic [2:0] a_i, input logic [7:0] d_i);
    @(posedge clk);
    addr <= a_i;
    wdata <= d_i;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  // Read data stands only in the cycle after the strobe
  task reg_rd(input logic [2:0] a_i, output logic [7:0] d_o);
    @(posedge clk);
    addr <= a_i;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d_o = rdata;
  endtask : reg_rd

  task rd_chk(input logic [2:0] a_i, input logic [7:0] exp_v);
    logic [7:0] d;
    reg_rd(a_i, d);
    chk(d, exp_v);
  endtask : rd_chk

  function logic par(input logic [7:0] d, input int n, input int p);
    logic x;
    x = (n == 7) ? ^d[6:0] : ^d;
    return (p == 1) ? 1'b0 : ((p == 2) ? ~x : x);
  endfunction : par

  // Builds start, data, optional parity and stop, then waits for the frame to end
  task send(input logic [7:0] d, input int n, input int p, input logic fl, input logic stp);
    logic [11:0] f;
    int ln;
    int k;
    f = 12'hFFF;
    f[0] = 1'b0;
    for (k = 0; k < n; k++) f[k + 1] = d[k];
    ln = n + 2;
    if (p != 0)
    begin
      f[n + 1] = par(d, n, p) ^ fl;
      ln++;
    end
    f[ln - 1] = stp;
    @(posedge clk);
    frame <= f;
    len <= 4'(ln);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while ((busy === 1'b1 || k < 3) && k < 200);
    repeat (3) @(posedge clk);
  endtask : send

  // Main sequence
  initial
  begin
    void'($urandom(37139));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_MODE, MODE_RESET);
    rd_chk(OFS_ERR, 8'h00);
    rd_chk(OFS_TXP, 8'h00);
    rd_chk(OFS_RXB, RXB_RESET);
    rd_chk(OFS_TXB, TXB_RESET);
    rd_chk(3'h7, 8'h00);
    // Every parity mode, good and corrupted parity, two stop bits set for transmit
    for (ps = 0; ps < 4; ps++)
      for (flip = 0; flip < 2; flip++)
      begin
        c8 = $urandom_range(1, 0);
        v = (ps == 3 && flip == 1) ? 8'h80 : 8'($urandom);
        reg_wr(OFS_MODE, 8'hE3 | 8'(ps << 3) | 8'(c8 << 2));
        base = n_rxd;
        send(v, c8 ? 8 : 7, ps, flip[0], 1'b1);
        chk(8'(n_rxd - base), 8'h01);
        rd_chk(OFS_ERR, (flip == 1 && ps >= 2) ? 8'h04 : 8'h00);
        rd_chk(OFS_ERR, 8'h00);
        rd_chk(OFS_RXB, (c8 == 1) ? v : {1'b0, v[6:0]});
      end
    // Low stop bit, error routed to the error pulse
    reg_wr(OFS_MODE, 8'hE4);
    base = n_rxe;
    send(8'h5A, 8, 0, 1'b0, 1'b0);
    chk(8'(n_rxe - base), 8'h01);
    rd_chk(OFS_ERR, 8'h02);
    repeat (30 * BC) @(posedge clk);
    reg_rd(OFS_RXB, v);
    reg_rd(OFS_ERR, v);
    // Overrun keeps the older byte
    reg_wr(OFS_MODE, 8'hE5);
    a = 8'($urandom);
    b = ~a;
    send(a, 8, 0, 1'b0, 1'b1);
    send(b, 8, 0, 1'b0, 1'b1);
    rd_chk(OFS_ERR, 8'h01);
    rd_chk(OFS_RXB, a);
    send(b, 8, 0, 1'b0, 1'b1);
    send(a, 8, 0, 1'b0, 1'b1);
    reg_wr(OFS_MODE, 8'hC5);
    rd_chk(OFS_ERR, 8'h00);
    base = n_rxd;
    send(8'h3C, 8, 0, 1'b0, 1'b1);
    chk(8'(n_rxd - base), 8'h00);
    rd_chk(OFS_RXB, b);
    reg_wr(OFS_MODE, 8'h45);
    rd_chk(OFS_RXB, 8'hFF);
    // Continuous transmission of two bytes
    reg_wr(OFS_MODE, 8'hE5);
    rxq.delete();
    base = n_txd;
    a = 8'($urandom);
    b = 8'($urandom);
    reg_wr(OFS_TXB, a);
    i = 0;
    do
    begin
      reg_rd(OFS_TXP, v);
      i++;
    end
    while (v[TXP_TXBF] !== 1'b0 && i < 50);
    reg_wr(OFS_TXB, b);
    rd_chk(OFS_TXP, 8'h03);
    rd_chk(OFS_TXB, b);
    i = 0;
    while (rxq.size() < 2 && i < 40 * BC)
    begin
      @(posedge clk);
      i++;
    end
    repeat (2 * BC) @(posedge clk);
    chk(8'(rxq.size()), 8'h02);
    chk(rxq[0], a);
    chk(rxq[1], b);
    chk(8'(n_txd - base), 8'h02);
    rd_chk(OFS_TXP, 8'h00);
    // Writes ignored while transmit is off
    reg_wr(OFS_MODE, 8'hA5);
    reg_wr(OFS_TXB, ~a);
    repeat (12 * BC) @(posedge clk);
    chk(8'(rxq.size()), 8'h02);
    rd_chk(OFS_TXB, b);
    // Disable in mid-frame with a byte waiting
    reg_wr(OFS_MODE, 8'hE5);
    reg_wr(OFS_TXB, a);
    repeat (2 * BC) @(posedge clk);
    reg_wr(OFS_TXB, b);
    rd_chk(OFS_TXP, 8'h03);
    reg_wr(OFS_MODE, 8'hA5);
    rd_chk(OFS_TXP, 8'h00);
    test_done();
  end
endmodule : test_uart_status_buffers
